/* shared/tmr_pkg.sv */
// Package for the dual legacy timer/counter block.
// Assumes an Avalon-MM byte address where each register takes one word.
package tmr_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_RUN_CTRL   = 8'h88;
  localparam logic [7:0] IDX_MODE_CTRL  = 8'h89;
  localparam logic [7:0] IDX_T0_LOW     = 8'h8a;
  localparam logic [7:0] IDX_T1_LOW     = 8'h8b;
  localparam logic [7:0] IDX_T0_HIGH    = 8'h8c;
  localparam logic [7:0] IDX_T1_HIGH    = 8'h8d;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h91;

  // Fields of the shared mode register.
  localparam int MODE_T0_LSB  = 0;
  localparam int CSEL_T0_BIT  = 2;
  localparam int GATE_T0_BIT  = 3;
  localparam int MODE_T1_LSB  = 4;
  localparam int CSEL_T1_BIT  = 6;
  localparam int GATE_T1_BIT  = 7;

  // Fields of the run control register.
  localparam int RUN_T0_BIT = 4;
  localparam int RUN_T1_BIT = 6;

  // Reset values.
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [1:0] BITS_RESET  = 2'h0;

  // Timer mode advances once every this many system clocks.
  localparam int         TIMER_DIV      = 12;
  localparam logic [3:0] DIV_LAST       = 4'(TIMER_DIV - 1);
  localparam logic [4:0] PRESCALE_LAST  = 5'h1f;

  typedef enum logic [1:0] {
    TMR_MODE_13BIT,
    TMR_MODE_16BIT,
    TMR_MODE_RELOAD,
    TMR_MODE_SPLIT
  } tmr_mode_t;
endpackage

/* verilog/tmr_dual_timer.sv */
// Two legacy timer/counters with a shared mode register and Avalon slave.
// Assumes count pins are asynchronous and isr_enter_i comes from logic on
// the system clock, one pulse per interrupt service entry.
`timescale 1ns/1ps
module tmr_dual_timer
  import tmr_pkg::*;
(
  input  wire logic        sys_clk_i,          // System clock, 100 MHz
  input  wire logic        rst_n_i,            // Async reset, active low
  input  wire logic [9:0]  avs_address_i,      // Byte address
  input  wire logic        avs_read_i,         // Read request
  input  wire logic        avs_write_i,        // Write request
  input  wire logic [31:0] avs_writedata_i,    // Write data
  input  wire logic [3:0]  avs_byteenable_i,   // Byte lanes
  output logic      [31:0] avs_readdata_o,     // Read data
  output logic             avs_waitrequest_o,  // Stall the master
  input  wire logic        timer_zero_input_pin_i, // Count/gate pin 0
  input  wire logic        timer_one_input_pin_i,  // Count/gate pin 1
  input  wire logic [1:0]  isr_enter_i,        // Service entered pulses
  output logic      [1:0]  overflow_flag_o,    // Overflow flags
  output logic             irq_o               // Masked interrupt level
);
  logic [7:0]  mode_ctrl;
  logic [1:0]  run;
  logic [7:0]  t0_low;
  logic [7:0]  t0_high;
  logic [7:0]  t1_low;
  logic [7:0]  t1_high;
  logic [1:0]  flag;
  logic [1:0]  mask;
  logic        ack;
  logic [1:0]  pin_meta;
  logic [1:0]  pin_sync;
  logic [1:0]  pin_prev;
  logic [3:0]  div_cnt;

  logic        tick;
  logic [1:0]  pin_fall;
  logic [7:0]  idx;
  logic        wr_hit;
  tmr_mode_t   mode0;
  tmr_mode_t   mode1;
  logic [1:0]  gate_ok;
  logic        t0_inc;
  logic        t1_inc;
  logic        t0h_inc;
  logic        t0_split;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [1:0]  ovf_set;
  logic [1:0]  next_flag;
  logic [7:0]  rd_val;

  assign idx    = avs_address_i[9:2];
  assign wr_hit = avs_write_i && ack && avs_byteenable_i[0]
                  && (avs_address_i[1:0] == 2'b00);
  assign mode0  = tmr_mode_t'(mode_ctrl[MODE_T0_LSB +: 2]);
  assign mode1  = tmr_mode_t'(mode_ctrl[MODE_T1_LSB +: 2]);
  assign t0_split = (mode0 == TMR_MODE_SPLIT);

  // Avalon slave: one wait cycle, then the access completes.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ack <= 1'b0;
    else
      ack <= (avs_read_i || avs_write_i) && !ack;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack);
  end

  always_comb
  begin
    unique case (idx)
      IDX_RUN_CTRL:   rd_val = {flag[1], run[1], flag[0], run[0], 4'h0};
      IDX_MODE_CTRL:  rd_val = mode_ctrl;
      IDX_T0_LOW:     rd_val = t0_low;
      IDX_T1_LOW:     rd_val = t1_low;
      IDX_T0_HIGH:    rd_val = t0_high;
      IDX_T1_HIGH:    rd_val = t1_high;
      IDX_IRQ_STATUS: rd_val = {6'h00, flag};
      IDX_IRQ_MASK:   rd_val = {6'h00, mask};
      default:        rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && !ack)
      avs_readdata_o <= {24'h000000, rd_val};
  end

  // Pins pass two flops; edges are found past the second one only.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta <= 2'b11;
      pin_sync <= 2'b11;
      pin_prev <= 2'b11;
    end
    else
    begin
      pin_meta <= {timer_one_input_pin_i, timer_zero_input_pin_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  assign pin_fall = pin_prev & ~pin_sync;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_cnt <= 4'h0;
    else if (div_cnt == DIV_LAST)
      div_cnt <= 4'h0;
    else
      div_cnt <= div_cnt + 4'h1;
  end
  assign tick = (div_cnt == DIV_LAST);

  assign gate_ok[0] = !mode_ctrl[GATE_T0_BIT] || pin_sync[0];
  assign gate_ok[1] = !mode_ctrl[GATE_T1_BIT] || pin_sync[1];
  assign t0_inc = run[0] && gate_ok[0]
                  && (mode_ctrl[CSEL_T0_BIT] ? pin_fall[0] : tick);
  // Timer one holds in mode 3; while timer zero is split it runs flagless.
  assign t1_inc = run[1] && gate_ok[1] && (mode1 != TMR_MODE_SPLIT)
                  && (mode_ctrl[CSEL_T1_BIT] ? pin_fall[1] : tick);
  assign t0h_inc = t0_split && run[1] && gate_ok[1] && tick;

  // Returns {overflow, high, low} after one count in the given mode.
  function automatic logic [16:0] step(input tmr_mode_t m,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    unique case (m)
      TMR_MODE_13BIT:
      begin
        r[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == PRESCALE_LAST)
        begin
          r[15:8] = hi + 8'h01;
          r[16]   = (hi == 8'hff);
        end
      end
      TMR_MODE_16BIT:
        r = {1'b0, hi, lo} + 17'h00001;
      TMR_MODE_RELOAD:
      begin
        r[7:0] = (lo == 8'hff) ? hi : lo + 8'h01;
        r[16]  = (lo == 8'hff);
      end
      TMR_MODE_SPLIT:
      begin
        r[7:0] = lo + 8'h01;
        r[16]  = (lo == 8'hff);
      end
    endcase
    return r;
  endfunction

  assign step0 = step(mode0, t0_low, t0_high);
  assign step1 = step(mode1, t1_low, t1_high);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_ctrl <= MODE_RESET;
      run       <= BITS_RESET;
      mask      <= BITS_RESET;
    end
    else if (wr_hit)
    begin
      if (idx == IDX_MODE_CTRL)
        mode_ctrl <= avs_writedata_i[7:0];
      if (idx == IDX_RUN_CTRL)
        run <= {avs_writedata_i[RUN_T1_BIT],
                avs_writedata_i[RUN_T0_BIT]};
      if (idx == IDX_IRQ_MASK)
        mask <= avs_writedata_i[1:0];
    end
  end

  // A software write to a count byte wins over the count in that cycle.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      t0_low  <= COUNT_RESET;
      t0_high <= COUNT_RESET;
    end
    else
    begin
      if (wr_hit && idx == IDX_T0_LOW)
        t0_low <= avs_writedata_i[7:0];
      else if (t0_inc)
        t0_low <= step0[7:0];
      if (wr_hit && idx == IDX_T0_HIGH)
        t0_high <= avs_writedata_i[7:0];
      else if (t0h_inc)
        t0_high <= t0_high + 8'h01;
      else if (t0_inc && !t0_split)
        t0_high <= step0[15:8];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      t1_low  <= COUNT_RESET;
      t1_high <= COUNT_RESET;
    end
    else
    begin
      if (wr_hit && idx == IDX_T1_LOW)
        t1_low <= avs_writedata_i[7:0];
      else if (t1_inc)
        t1_low <= step1[7:0];
      if (wr_hit && idx == IDX_T1_HIGH)
        t1_high <= avs_writedata_i[7:0];
      else if (t1_inc)
        t1_high <= step1[15:8];
    end
  end

  // In split mode timer one's flag belongs to the high byte of timer zero.
  assign ovf_set[0] = t0_inc && step0[16];
  assign ovf_set[1] = t0_split ? (t0h_inc && t0_high == 8'hff)
                               : (t1_inc && step1[16]);

  // A new overflow wins over a clear from software or service entry.
  always_comb
  begin
    next_flag = flag;
    if (wr_hit && idx == IDX_IRQ_STATUS)
      next_flag = next_flag & ~avs_writedata_i[1:0];
    next_flag = (next_flag & ~isr_enter_i) | ovf_set;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flag            <= BITS_RESET;
      overflow_flag_o <= BITS_RESET;
      irq_o           <= 1'b0;
    end
    else
    begin
      flag            <= next_flag;
      overflow_flag_o <= next_flag;
      irq_o           <= |(next_flag & mask);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence tick_gap_s;
    !tick [*8] ##1 !tick [*3];
  endsequence

  div_period_a: assert property (tick |=> tick_gap_s ##1 tick)
    else $error("timer tick spacing is not twelve clocks");
  run_stop_a: assert property (!run[0] && !wr_hit && !t0_split
                               |=> $stable(t0_low) && $stable(t0_high))
    else $error("stopped timer zero changed");
  gate_hold_a: assert property (mode_ctrl[GATE_T0_BIT]
                                && !pin_sync[0] && !wr_hit
                                |=> $stable(t0_low))
    else $error("gated timer zero counted");
  ext_count_a: assert property (t0_inc && mode_ctrl[CSEL_T0_BIT]
                                && mode0 == TMR_MODE_16BIT && !wr_hit
                                && t0_low != 8'hff
                                |=> t0_low == 8'($past(t0_low) + 8'h01))
    else $error("counter mode missed a pin edge");
  reload_a: assert property (mode1 == TMR_MODE_RELOAD && t1_inc
                             && t1_low == 8'hff && !wr_hit && !t0_split
                             |=> t1_low == $past(t1_high) && flag[1])
    else $error("auto reload did not load the high byte");
  prescale_a: assert property (mode0 == TMR_MODE_13BIT && t0_inc
                               && t0_low[4:0] == PRESCALE_LAST && !wr_hit
                               |=> t0_high == 8'($past(t0_high) + 8'h01))
    else $error("prescaler carry lost");
  flag_set_a: assert property (ovf_set[0] |=> flag[0]
                               && (irq_o || !$past(mask[0])))
    else $error("overflow did not raise the flag");
  isr_clear_a: assert property (isr_enter_i[0] && !ovf_set[0]
                                |=> !flag[0])
    else $error("service entry did not clear the flag");
  t1_hold_a: assert property (mode1 == TMR_MODE_SPLIT && !wr_hit
                              |=> $stable(t1_low) && $stable(t1_high))
    else $error("timer one counted in mode 3");
  split_high_a: assert property (t0h_inc && !wr_hit
                                 |=> t0_high == 8'($past(t0_high) + 8'h01))
    else $error("split high byte did not count");
  mode_rb_a: assert property (wr_hit && idx == IDX_MODE_CTRL
                              |=> mode_ctrl == $past(avs_writedata_i[7:0]))
    else $error("mode register did not take the write");
  count_wr_a: assert property (wr_hit && idx == IDX_T1_LOW
                               |=> t1_low == $past(avs_writedata_i[7:0]))
    else $error("count byte did not take the write");
endmodule // tmr_dual_timer

/* dv/tmr_pin_model.sv */
// Model of the two external count/gate pins of the dual timer.
// Assumes the bench commands bursts; pins rest at the commanded idle level.
`timescale 1ns/1ps
module tmr_pin_model
(
  input  wire logic       sys_clk_i, // System clock
  input  wire logic       rst_n_i,   // Async reset, active low
  input  wire logic [1:0] idle_i,    // Level between bursts
  input  wire logic [1:0] start_i,   // Begin a burst
  input  wire logic [3:0] pulses_i,  // Falling edges per burst
  output logic      [1:0] pin_o      // Pin levels
);
  for (genvar k = 0; k < 2; k++)
  begin : g_pin
    logic [6:0] ph;
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        ph <= 7'h00;
      else if (start_i[k])
        ph <= 7'(pulses_i) * 7'h06;
      else if (ph != 7'h00)
        ph <= ph - 7'h01;
    end
    // Three clocks low, three high: wide enough for the two-flop sampler.
    assign pin_o[k] = (ph == 7'h00) ? idle_i[k] :
                      (((ph - 7'h01) % 7'h06) < 7'h03);
  end
endmodule // tmr_pin_model

/* dv/tb_top.sv */
// Self-checking bench for the dual timer over its Avalon-MM slave port.
// Assumes the pin model drives both count/gate pins.
`timescale 1ns/1ps
module tb_top
  import tmr_pkg::*;
;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, ws, irq, wreq;
  logic [9:0]  addr = '0;
  logic [31:0] wdat = '0, rdat, rs;
  logic [1:0]  pin, isr = 2'h0, flag, fs, idle = 2'h3, start = 2'h0;
  logic [3:0]  pulses = 4'h0;
  logic [31:0] q;
  int          n_fail = 0, checked = 0;

  initial forever #5 clk = ~clk;
  // Snapshots taken mid-cycle hold what the next rising edge samples.
  always @(negedge clk)
  begin
    ws <= wreq;
    rs <= rdat;
    fs <= flag;
  end

  tmr_dual_timer i_dut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'h1),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .timer_zero_input_pin_i(pin[0]), .timer_one_input_pin_i(pin[1]),
    .isr_enter_i(isr), .overflow_flag_o(flag), .irq_o(irq));
  tmr_pin_model i_pins (.sys_clk_i(clk), .rst_n_i(rst_n), .idle_i(idle),
    .start_i(start), .pulses_i(pulses), .pin_o(pin));

  task results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (ws === 1'b0)
        break;
    end
    q = rs;
    wr <= 1'b0;
    rd <= 1'b0;
    if (i == 50)
    begin
      n_fail++;
      results;
    end
  endtask

  task put(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task get(input string what, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(what, q, {24'h0, e});
  endtask

  // Counts clocks until the flag rises and checks it fell inside lo..hi.
  task wait_flag(input int k, input int lo, input int hi, input string what);
    int n;
    for (n = 0; n < hi + 20 && fs[k] !== 1'b1; n++)
      @(negedge clk);
    if (n >= hi + 20)
    begin
      n_fail++;
      results;
    end
    chk(what, {31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  task isr_pulse(input logic [1:0] b);
    @(posedge clk);
    isr <= b;
    @(posedge clk);
    isr <= 2'h0;
    repeat (2) @(negedge clk);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    get("mode reset", IDX_MODE_CTRL, MODE_RESET);
    for (int i = 0; i < 4; i++)
      get("count reset", IDX_T0_LOW + 8'(i), COUNT_RESET);
    for (int i = 0; i < 4; i++)
    begin
      put(IDX_T0_LOW + 8'(i), 8'h3c ^ 8'(i));
      get("count rw", IDX_T0_LOW + 8'(i), 8'h3c ^ 8'(i));
    end
    put(IDX_MODE_CTRL, 8'hb5);
    get("mode rw", IDX_MODE_CTRL, 8'hb5);
    get("unmapped", 8'h40, 8'h00);
    $display("test registers done");
    put(IDX_T0_LOW, 8'hf6);
    put(IDX_T0_HIGH, 8'hff);
    put(IDX_MODE_CTRL, 8'h01);
    repeat (40) @(negedge clk);
    get("stopped count", IDX_T0_LOW, 8'hf6);
    put(IDX_RUN_CTRL, 8'h11);
    wait_flag(0, 108, 124, "mode1 overflow time");
    get("run view", IDX_RUN_CTRL, 8'h30);
    chk("irq masked", {31'h0, irq}, 32'h0);
    put(IDX_IRQ_MASK, 8'h01);
    repeat (2) @(negedge clk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    put(IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(negedge clk);
    chk("irq cleared", {29'h0, fs, irq}, 32'h0);
    $display("test mode1 done");
    put(IDX_RUN_CTRL, 8'h00);
    put(IDX_T0_LOW, 8'hff);
    put(IDX_T0_HIGH, 8'hff);
    put(IDX_MODE_CTRL, 8'h00);
    put(IDX_RUN_CTRL, 8'h11);
    wait_flag(0, 0, 16, "mode0 overflow time");
    put(IDX_RUN_CTRL, 8'h00);
    get("mode0 low", IDX_T0_LOW, 8'he0);
    get("mode0 high", IDX_T0_HIGH, 8'h00);
    isr_pulse(2'h1);
    chk("service clear 0", {30'h0, fs}, 32'h0);
    $display("test mode0 done");
    put(IDX_T1_HIGH, 8'hf0);
    put(IDX_T1_LOW, 8'hfe);
    put(IDX_MODE_CTRL, 8'h20);
    put(IDX_RUN_CTRL, 8'h42);
    wait_flag(1, 12, 28, "mode2 overflow time");
    put(IDX_RUN_CTRL, 8'h00);
    get("reload", IDX_T1_LOW, 8'hf0);
    isr_pulse(2'h2);
    chk("service clear 1", {30'h0, fs}, 32'h0);
    $display("test mode2 done");
    // Timer one's own flag is not relied on while timer zero is split.
    put(IDX_T0_HIGH, 8'hff);
    put(IDX_T0_LOW, 8'h80);
    put(IDX_T1_LOW, 8'h55);
    put(IDX_MODE_CTRL, 8'h73);
    put(IDX_RUN_CTRL, 8'h42);
    wait_flag(1, 0, 16, "split high overflow");
    chk("split low flag", {31'h0, fs[0]}, 32'h0);
    get("split low held", IDX_T0_LOW, 8'h80);
    get("timer one mode3", IDX_T1_LOW, 8'h55);
    put(IDX_RUN_CTRL, 8'h00);
    $display("test mode3 done");
    put(IDX_T0_LOW, 8'hfd);
    put(IDX_T0_HIGH, 8'hff);
    put(IDX_MODE_CTRL, 8'h05);
    put(IDX_RUN_CTRL, 8'h11);
    repeat (60) @(negedge clk);
    chk("counter no edges", {31'h0, fs[0]}, 32'h0);
    @(posedge clk);
    pulses <= 4'h3;
    start <= 2'h1;
    @(posedge clk);
    start <= 2'h0;
    wait_flag(0, 12, 40, "counter overflow");
    $display("test counter done");
    put(IDX_RUN_CTRL, 8'h00);
    put(IDX_IRQ_STATUS, 8'h03);
    put(IDX_T0_LOW, 8'hff);
    put(IDX_T0_HIGH, 8'hff);
    put(IDX_MODE_CTRL, 8'h09);
    @(posedge clk);
    idle <= 2'h2;
    put(IDX_RUN_CTRL, 8'h11);
    repeat (60) @(negedge clk);
    chk("gate closed", {31'h0, fs[0]}, 32'h0);
    @(posedge clk);
    idle <= 2'h3;
    wait_flag(0, 0, 20, "gate open");
    $display("test gate done");
    results;
  end

  initial
  begin
    #400us;
    n_fail++;
    results;
  end
endmodule // tb_top
